// ### rst_seq_pkg.sv
package rst_seq_pkg;

   // Start-up timer length in system clock periods, and the counter width.
   localparam int SST_CYCLES = 1024;
   localparam int POR_EXTRA_CYCLES = 1024;
   localparam int TMR_W = 12;

   // Register offsets (byte addresses) and decode width.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EVT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;

   // Status register fields.
   localparam int STAT_TO_BIT = 0;
   localparam int STAT_PDF_BIT = 1;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_KIND_LSB = 8;

   // Event bits, shared by the sticky status and the mask register.
   localparam int EVT_W = 4;
   localparam int EVT_EXT = 0;
   localparam int EVT_WDT = 1;
   localparam int EVT_WARM = 2;
   localparam int EVT_HALT = 3;
   localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
   localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

   // Value that port data and port direction registers take on a full reset.
   localparam logic [7:0] PORT_INIT_VALUE = 8'hff;

   // AHB transfer type bit that marks an active transfer (NONSEQ or SEQ).
   localparam int HTRANS_ACTIVE_BIT = 1;

   // Sequencer states.
   typedef enum logic [2:0] {ST_BOOT, ST_POR, ST_EXT, ST_SST, ST_RUN, ST_HALT} seq_state_t;

   // What a start-up delay ends: a full reset, a warm reset or a plain wake.
   typedef enum logic [1:0] {WK_FULL, WK_WARM, WK_RESUME} wake_kind_t;

endpackage

// ### sst_if.sv
`timescale 1ns/1ps
// Link between the sequencer and its start-up delay counter.
interface sst_if import rst_seq_pkg::*; ();
   logic start;             // One-cycle pulse that loads the counter.
   logic [TMR_W-1:0] load;  // Number of cycles to count.
   logic busy;              // High while the count runs.
   logic done;              // High in the last cycle of the count.
   modport ctl (output start, output load, input busy, input done);
   modport tmr (input start, input load, output busy, output done);
endinterface

// ### startup_timer.sv
`timescale 1ns/1ps
// Down counter that times the start-up delays.
module startup_timer import rst_seq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   sst_if.tmr t
);

   logic [TMR_W-1:0] cnt_r;   // Cycles left.
   logic [TMR_W-1:0] cnt_nxt;
   logic [TMR_W-1:0] elapsed_r;   // Cycles since the last start, for checking.
   logic [TMR_W-1:0] load_seen_r; // Length of the running count, for checking.

   // A start always reloads, so a restart in the middle of a count is safe.
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (t.start)
      begin
         cnt_nxt = t.load;
      end
      else if (cnt_r != '0)
      begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign t.busy = (cnt_r != '0);
   assign t.done = (cnt_r == TMR_W'(1));

   // Helper logic that only the check below reads.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         elapsed_r <= '0;
         load_seen_r <= '0;
      end
      else if (t.start)
      begin
         elapsed_r <= TMR_W'(1);
         load_seen_r <= t.load;
      end
      else
      begin
         elapsed_r <= elapsed_r + 1'b1;
      end
   end

   chk_timer_done_length: assert property (@(posedge hclk) disable iff (!hresetn)
      t.done |-> elapsed_r == load_seen_r)
      else $error("start-up delay ended after the wrong number of cycles");

endmodule

// ### reset_sequencer.sv
`timescale 1ns/1ps
module reset_sequencer import rst_seq_pkg::*;
#(
   parameter int POR_EXTRA = POR_EXTRA_CYCLES,
   parameter int SST_LEN = SST_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic external_reset_input_n,
   input wire logic watchdog_timeout,
   input wire logic halt_enter,
   input wire logic watchdog_clear_instruction,
   input wire logic wake_event,
   output logic unit_reset,
   output logic watchdog_reset,
   output logic pc_sp_clear,
   output logic warm_reset,
   output logic exec_hold,
   output logic [7:0] port_init_data,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic irq
);

   sst_if sst ();

   // Reset pin synchroniser; the first stage feeds only the second.
   logic ext_sync1_r;
   logic ext_sync2_r;
   logic ext_low;   // External reset asserted, in the clock domain.

   // Sequencer state and its next values.
   seq_state_t state_r;
   seq_state_t state_nxt;
   wake_kind_t kind_r;     // What the running start-up delay ends.
   wake_kind_t kind_nxt;
   logic sst_need_r;       // The external reset hold must end in a start-up delay.
   logic sst_need_nxt;
   logic to_r;
   logic to_nxt;
   logic pdf_r;
   logic pdf_nxt;
   logic [EVT_W-1:0] evt_set;   // Events seen in this cycle.
   logic warm_pulse;

   // Registered outputs towards the functional units.
   logic unit_reset_nxt;
   logic wdt_reset_nxt;
   logic pc_sp_clear_nxt;

   // Bus state.
   logic ap_valid_r;
   logic ap_write_r;
   logic [ADDR_W-1:0] ap_addr_r;
   logic [31:0] hrdata_nxt;
   logic [EVT_W-1:0] evt_r;
   logic [EVT_W-1:0] evt_nxt;
   logic [EVT_W-1:0] mask_r;
   logic [EVT_W-1:0] mask_nxt;
   logic irq_nxt;

   // True when a bus address hits the given register.
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      hit = (addr == ofs);
   endfunction

   startup_timer u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .t(sst.tmr)
   );

   // The pin is asynchronous, so it passes two flops before any use.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Reset to released: reading asserted here would cut the power-on delay short.
         ext_sync1_r <= 1'b1;
         ext_sync2_r <= 1'b1;
      end
      else
      begin
         ext_sync1_r <= external_reset_input_n;
         ext_sync2_r <= ext_sync1_r;
      end
   end

   assign ext_low = ~ext_sync2_r;

   // Sequencer: the external reset is tested first in every state but ST_BOOT.
   always_comb
   begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      sst_need_nxt = sst_need_r;
      to_nxt = to_r;
      pdf_nxt = pdf_r;
      evt_set = '0;
      warm_pulse = 1'b0;
      sst.start = 1'b0;
      sst.load = TMR_W'(SST_LEN);
      unique case (state_r)
         ST_BOOT:
         begin
            // Power-on gets its extra delay first.
            sst.start = 1'b1;
            sst.load = TMR_W'(POR_EXTRA);
            state_nxt = ST_POR;
         end
         ST_POR:
         begin
            if (ext_low)
            begin
               state_nxt = ST_EXT;
               sst_need_nxt = 1'b1;
            end
            else if (sst.done)
            begin
               sst.start = 1'b1;
               kind_nxt = WK_FULL;
               state_nxt = ST_SST;
            end
         end
         ST_EXT:
         begin
            // Internal reset stays on while the pin is low.
            if (!ext_low)
            begin
               if (sst_need_r)
               begin
                  sst.start = 1'b1;
                  kind_nxt = WK_FULL;
                  state_nxt = ST_SST;
               end
               else
               begin
                  state_nxt = ST_RUN;
               end
            end
         end
         ST_SST:
         begin
            // An external reset restarts the whole delay.
            if (ext_low)
            begin
               state_nxt = ST_EXT;
               sst_need_nxt = 1'b1;
               evt_set[EVT_EXT] = 1'b1;
            end
            else if (sst.done)
            begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (ext_low)
            begin
               // Flags are left alone, even with a watchdog time-out pending.
               state_nxt = ST_EXT;
               sst_need_nxt = 1'b0;
               evt_set[EVT_EXT] = 1'b1;
            end
            else if (watchdog_timeout)
            begin
               // The oscillator runs, so a one-cycle reset pulse suffices.
               state_nxt = ST_EXT;
               sst_need_nxt = 1'b0;
               to_nxt = 1'b1;
               evt_set[EVT_WDT] = 1'b1;
            end
            else if (halt_enter)
            begin
               state_nxt = ST_HALT;
               to_nxt = 1'b0;
               pdf_nxt = 1'b1;
               evt_set[EVT_HALT] = 1'b1;
            end
            else if (watchdog_clear_instruction)
            begin
               pdf_nxt = 1'b0;
            end
         end
         ST_HALT:
         begin
            if (ext_low)
            begin
               state_nxt = ST_EXT;
               sst_need_nxt = 1'b1;
               to_nxt = 1'b0;
               pdf_nxt = 1'b1;
               evt_set[EVT_EXT] = 1'b1;
            end
            else if (watchdog_timeout)
            begin
               // Warm reset: only PC and SP are touched.
               sst.start = 1'b1;
               kind_nxt = WK_WARM;
               state_nxt = ST_SST;
               to_nxt = 1'b1;
               pdf_nxt = 1'b1;
               warm_pulse = 1'b1;
               evt_set[EVT_WDT] = 1'b1;
               evt_set[EVT_WARM] = 1'b1;
            end
            else if (wake_event)
            begin
               sst.start = 1'b1;
               kind_nxt = WK_RESUME;
               state_nxt = ST_SST;
            end
         end
      endcase
   end

   // Unit-facing levels follow the next state so that they come from flops.
   always_comb
   begin
      unit_reset_nxt = (state_nxt == ST_BOOT) || (state_nxt == ST_POR) ||
         (state_nxt == ST_EXT) || (state_nxt == ST_SST && kind_nxt == WK_FULL);
      // The watchdog is released as the start-up delay begins.
      wdt_reset_nxt = (state_nxt == ST_BOOT) || (state_nxt == ST_POR) ||
         (state_nxt == ST_EXT);
      pc_sp_clear_nxt = unit_reset_nxt ||
         (state_nxt == ST_SST && kind_nxt == WK_WARM);
   end

   // Power-up is the async reset: both flags start at zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= ST_BOOT;
         kind_r <= WK_FULL;
         sst_need_r <= 1'b1;
         to_r <= 1'b0;
         pdf_r <= 1'b0;
         unit_reset <= 1'b1;
         watchdog_reset <= 1'b1;
         pc_sp_clear <= 1'b1;
         warm_reset <= 1'b0;
         exec_hold <= 1'b1;
         port_init_data <= PORT_INIT_VALUE;
      end
      else
      begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         sst_need_r <= sst_need_nxt;
         to_r <= to_nxt;
         pdf_r <= pdf_nxt;
         unit_reset <= unit_reset_nxt;
         watchdog_reset <= wdt_reset_nxt;
         pc_sp_clear <= pc_sp_clear_nxt;
         warm_reset <= warm_pulse;
         exec_hold <= (state_nxt != ST_RUN);
         port_init_data <= PORT_INIT_VALUE;
      end
   end

   assign timeout_flag = to_r;
   assign powerdown_flag = pdf_r;

   // AHB-Lite slave: zero wait states, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Bus next values; read data are fetched in the address phase.
   always_comb
   begin
      hrdata_nxt = '0;
      if (hsel && hready && htrans[HTRANS_ACTIVE_BIT] && !hwrite)
      begin
         if (hit(haddr[ADDR_W-1:0], OFS_STATUS))
         begin
            hrdata_nxt[STAT_TO_BIT] = to_r;
            hrdata_nxt[STAT_PDF_BIT] = pdf_r;
            hrdata_nxt[STAT_STATE_LSB +: 3] = state_r;
            hrdata_nxt[STAT_KIND_LSB +: 2] = kind_r;
         end
         else if (hit(haddr[ADDR_W-1:0], OFS_EVT))
         begin
            hrdata_nxt[EVT_W-1:0] = evt_r;
         end
         else if (hit(haddr[ADDR_W-1:0], OFS_MASK))
         begin
            hrdata_nxt[EVT_W-1:0] = mask_r;
         end
      end
      // Write one to clear; a new event in the same cycle wins.
      evt_nxt = evt_r;
      mask_nxt = mask_r;
      if (ap_valid_r && ap_write_r)
      begin
         if (hit(ap_addr_r, OFS_EVT))
         begin
            evt_nxt = evt_r & ~hwdata[EVT_W-1:0];
         end
         else if (hit(ap_addr_r, OFS_MASK))
         begin
            mask_nxt = hwdata[EVT_W-1:0];
         end
      end
      evt_nxt = evt_nxt | evt_set;
      irq_nxt = |(evt_nxt & mask_nxt);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= '0;
         hrdata <= '0;
         evt_r <= EVT_RESET;
         mask_r <= MASK_RESET;
         irq <= 1'b0;
      end
      else
      begin
         ap_valid_r <= hsel && hready && htrans[HTRANS_ACTIVE_BIT];
         ap_write_r <= hwrite;
         ap_addr_r <= haddr[ADDR_W-1:0];
         hrdata <= hrdata_nxt;
         evt_r <= evt_nxt;
         mask_r <= mask_nxt;
         irq <= irq_nxt;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_powerup_flags_zero: assert property (
      state_r == ST_BOOT |-> !to_r && !pdf_r && unit_reset && exec_hold)
      else $error("power-up state without cleared flags and reset");
   chk_ext_run_keeps: assert property (
      state_r == ST_RUN && ext_low |=> to_r == $past(to_r) && pdf_r == $past(pdf_r) && unit_reset)
      else $error("external reset while running changed a flag");
   chk_ext_beats_wdt: assert property (
      state_r == ST_HALT && ext_low && watchdog_timeout |=> !to_r && unit_reset && !warm_reset)
      else $error("watchdog time-out won over external reset");
   chk_ext_halt_wake: assert property (
      state_r == ST_HALT && ext_low |=> !to_r && pdf_r)
      else $error("external wake from halt left wrong flags");
   chk_wdt_run_flags: assert property (
      state_r == ST_RUN && !ext_low && watchdog_timeout |=> to_r && pdf_r == $past(pdf_r) && unit_reset)
      else $error("watchdog reset while running left wrong flags");
   chk_wdt_warm_reset: assert property (
      state_r == ST_HALT && !ext_low && watchdog_timeout |=> warm_reset && pc_sp_clear && !unit_reset
      ##1 !warm_reset && pc_sp_clear && !unit_reset)
      else $error("warm reset touched more than PC and SP");
   chk_wdt_halt_flags: assert property (
      state_r == ST_HALT && !ext_low && watchdog_timeout |=> to_r && pdf_r)
      else $error("watchdog wake from halt left wrong flags");
   chk_halt_entry_flags: assert property (
      state_r == ST_RUN && !ext_low && !watchdog_timeout && halt_enter |=> !to_r && pdf_r && exec_hold)
      else $error("halt entry left wrong flags");
   chk_clear_instr_pdf: assert property (
      state_r == ST_RUN && !ext_low && !watchdog_timeout && !halt_enter && watchdog_clear_instruction
      |=> !pdf_r)
      else $error("watchdog clear instruction kept powerdown flag");
   chk_pin_sync_delay: assert property (
      state_r == ST_RUN && $fell(external_reset_input_n) |=> state_r == ST_RUN)
      else $error("reset pin acted before two synchroniser stages");
   chk_full_hold_sst: assert property (
      state_r == ST_SST && kind_r == WK_FULL |-> unit_reset && pc_sp_clear && exec_hold)
      else $error("internal reset released before start-up delay ended");
   chk_sst_timer_busy: assert property (
      state_r == ST_SST |-> sst.busy)
      else $error("start-up delay state without a running timer");
   chk_por_extra_first: assert property (
      state_r == ST_SST && $past(state_r) == ST_POR |-> $past(sst.done))
      else $error("start-up delay began before power-on extra delay ended");

   cov_warm_reset: cover property (state_r == ST_HALT && !ext_low && watchdog_timeout);
   cov_ext_wake: cover property (state_r == ST_HALT && ext_low);
   cov_wdt_run: cover property (state_r == ST_RUN && !ext_low && watchdog_timeout);
   cov_run_after_sst: cover property (state_r == ST_SST ##1 state_r == ST_RUN);

endmodule

// ### reset_partner.sv
`timescale 1ns/1ps
// Stand-in for the reset pin circuit and the watchdog.
// It turns the bench's requests into a pin level and strobes one clock later.
module reset_partner
(
   input wire logic hclk,
   input wire logic pin_req,
   input wire logic [2:0] strobe_req,
   output logic external_reset_input_n,
   output logic watchdog_timeout,
   output logic halt_enter,
   output logic watchdog_clear_instruction,
   output logic wake_event
);
   // Strobe codes: 0 idle, 1 watchdog overflow, 2 halt, 3 clear instruction, 4 wake.
   always_ff @(posedge hclk)
   begin
      external_reset_input_n <= pin_req;
      watchdog_timeout <= (strobe_req == 3'h1);
      halt_enter <= (strobe_req == 3'h2);
      watchdog_clear_instruction <= (strobe_req == 3'h3);
      wake_event <= (strobe_req == 3'h4);
   end
endmodule

// ### tb.sv
`timescale 1ns/1ps
// Self-checking bench; the delay counts are shortened so the run stays brief.
module tb import rst_seq_pkg::*; ;
   localparam int PX = 4; // Shortened power-on extra delay.
   localparam int SL = 8; // Shortened start-up delay.
   // One table access: write flag, offset, data, read mask, expected read value.
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_t;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic ext_n, wdt, halt, clr, wake;
   logic pin_req;
   logic [2:0] strobe_req;
   logic unit_reset, watchdog_reset, pc_sp_clear, warm_reset, exec_hold;
   logic timeout_flag, powerdown_flag;
   logic [7:0] port_init_data;
   int error_cnt, num_checks, cyc, n;
   row_t rows [9];

   reset_sequencer #(.POR_EXTRA(PX), .SST_LEN(SL)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .external_reset_input_n(ext_n), .watchdog_timeout(wdt),
      .halt_enter(halt), .watchdog_clear_instruction(clr), .wake_event(wake),
      .unit_reset(unit_reset), .watchdog_reset(watchdog_reset), .pc_sp_clear(pc_sp_clear),
      .warm_reset(warm_reset), .exec_hold(exec_hold), .port_init_data(port_init_data),
      .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));
   reset_partner partner (.hclk(hclk), .pin_req(pin_req), .strobe_req(strobe_req),
      .external_reset_input_n(ext_n),
      .watchdog_timeout(wdt), .halt_enter(halt), .watchdog_clear_instruction(clr),
      .wake_event(wake));

   // Clock of 100 ns period.
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // A hang ends the run as a mismatch; the whole run needs a few hundred cycles.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         results();
      end
   end

   // Compares a seen value with the expected one and counts the outcome.
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Single AHB word transfer; read data is taken at the edge that ends the data phase.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Counts cycles until execution is released, bounded so a stuck hold cannot hang.
   task automatic wait_run();
      n = 0;
      while (exec_hold !== 1'b0 && n < 3000)
      begin
         @(posedge hclk);
         #1;
         n++;
      end
   endtask

   // Holds reset eleven cycles and checks what the units see after ten.
   task automatic do_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      #1;
      check({pc_sp_clear, unit_reset, exec_hold}, 3'h7, "reset outputs");
      check(watchdog_reset, 1'b1, "watchdog cleared");
      check({timeout_flag, powerdown_flag, irq}, 3'h0, "reset flags");
      check(port_init_data, 8'hff, "port init");
      @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   // Requests a reset pin level; the partner puts it on the pin at the next edge.
   task automatic pin(input logic v);
      @(posedge hclk);
      pin_req <= v;
   endtask

   // One-cycle strobe through the partner; the design acts at the edge this returns on.
   task automatic pulse(input logic [2:0] k);
      @(posedge hclk);
      strobe_req <= k;
      @(posedge hclk);
      strobe_req <= 3'h0;
      @(posedge hclk);
   endtask

   task automatic tend(input string s);
      $display("test %s finished", s);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence: table of register accesses, then the reset causes one by one.
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pin_req = 1'b1;
      strobe_req = 3'h0;
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      rows = '{'{1'b1, OFS_EVT, 32'hf, 32'h0, 32'h0}, '{1'b0, OFS_EVT, 32'h0, 32'hf, 32'h0},
         '{1'b1, OFS_MASK, 32'hf, 32'h0, 32'h0}, '{1'b0, OFS_MASK, 32'h0, 32'hf, 32'hf},
         '{1'b0, 8'h0c, 32'h0, 32'hffffffff, 32'h0}, '{1'b1, OFS_STATUS, 32'hff, 32'h0, 32'h0},
         '{1'b0, OFS_STATUS, 32'h0, 32'h73, 32'h40}, '{1'b1, OFS_MASK, 32'h0, 32'h0, 32'h0},
         '{1'b0, OFS_MASK, 32'h0, 32'hf, 32'h0}};
      do_reset();
      wait_run();
      check(n >= PX + SL && n <= PX + SL + 4, 1'b1, "power-on delay");
      check({timeout_flag, powerdown_flag}, 2'h0, "power-up flags");
      tend("power-on");
      foreach (rows[i])
      begin
         ahb(rows[i].wr, rows[i].a, rows[i].d);
         check(hresp, 1'b0, "okay response");
         if (!rows[i].wr)
            check(rd & rows[i].m, rows[i].e, "register row");
      end
      tend("registers");
      // Watchdog overflow while halted: warm reset with only the start-up delay.
      ahb(1'b1, OFS_MASK, 32'h1 << EVT_WDT);
      pulse(3'h2);
      #1;
      check({timeout_flag, powerdown_flag}, 2'b01, "halt entry flags");
      pulse(3'h1);
      #1;
      check({warm_reset, pc_sp_clear, unit_reset}, 3'b110, "warm reset");
      check({timeout_flag, powerdown_flag}, 2'b11, "watchdog wake flags");
      @(posedge hclk);
      #1;
      check(warm_reset, 1'b0, "warm pulse length");
      wait_run();
      check(n >= SL - 2 && n <= SL + 2, 1'b1, "wake delay");
      check(irq, 1'b1, "irq raised");
      // Halt entry, the watchdog reset and the warm reset each left their event bit.
      ahb(1'b0, OFS_EVT, 32'h0);
      check(rd, (32'h1 << EVT_WDT) | (32'h1 << EVT_WARM) | (32'h1 << EVT_HALT), "events");
      ahb(1'b1, OFS_MASK, 32'h0);
      #1;
      check(irq, 1'b0, "irq masked");
      ahb(1'b1, OFS_EVT, 32'hf);
      ahb(1'b1, OFS_MASK, 32'h1 << EVT_WDT);
      #1;
      check(irq, 1'b0, "irq cleared");
      tend("watchdog wake");
      // Watchdog overflow while running keeps the powerdown flag.
      pulse(3'h1);
      #1;
      check({unit_reset, watchdog_reset, timeout_flag, powerdown_flag}, 4'hf, "run wdt");
      wait_run();
      check(n <= 3 && irq === 1'b1, 1'b1, "run wdt release");
      pulse(3'h3);
      #1;
      check({timeout_flag, powerdown_flag}, 2'b10, "clear instruction");
      tend("watchdog run");
      // Reset pin while halted, then while running.
      pulse(3'h2);
      pin(1'b0);
      repeat (4) @(posedge hclk);
      #1;
      check({unit_reset, timeout_flag, powerdown_flag}, 3'b101, "pin wake");
      pin(1'b1);
      wait_run();
      check(n >= SL, 1'b1, "pin wake delay");
      pin(1'b0);
      repeat (4) @(posedge hclk);
      #1;
      check(unit_reset, 1'b1, "pin run reset");
      pin(1'b1);
      wait_run();
      check(n <= 6, 1'b1, "pin run release");
      check({timeout_flag, powerdown_flag}, 2'b01, "pin run flags");
      tend("reset pin");
      // Plain wake from halt, then pin and watchdog seen in the same cycle.
      pulse(3'h2);
      pulse(3'h4);
      wait_run();
      check(n >= SL - 2 && n <= SL + 2, 1'b1, "resume delay");
      pulse(3'h2);
      pin(1'b0);
      @(posedge hclk);
      pulse(3'h1);
      #1;
      check({warm_reset, timeout_flag, powerdown_flag}, 3'b001, "pin beats wdt");
      pin(1'b1);
      wait_run();
      tend("wake and priority");
      do_reset();
      wait_run();
      check({timeout_flag, powerdown_flag}, 2'h0, "second power-up");
      tend("second reset");
      results();
   end
endmodule
